//--- hdl/spacz_pkg.sv
// Package: constants and types for the setpoint alarm and colour-zone block
package spacz_pkg;
    localparam int unsigned READING_W = 16;
    localparam int unsigned NUM_SP    = 4;
    localparam int unsigned DEB_W     = 16;
    // Debounce settle time in microseconds, and its cycle count at 50 MHz
    localparam int unsigned DEB_TIME_US  = 5000;
    localparam int unsigned CLK_MHZ      = 50;
    localparam int unsigned DEB_CYCLES   = DEB_TIME_US * CLK_MHZ;
    localparam logic [3:0]  POL_RESET    = 4'hF;
    localparam logic [7:0]  BRIGHT_RESET = 8'hFF;
    // Setpoint reset values, encoding as two's complement counts
    localparam logic signed [15:0] SP_RESET = 16'h270F;

    typedef enum logic [1:0] {
        SPACZ_GREEN  = 2'h0,
        SPACZ_ORANGE = 2'h1,
        SPACZ_RED    = 2'h2
    } spacz_color_t;

    // Menu states, Gray-coded along the programming path from RUN to COL4
    typedef enum logic [3:0] {
        SPACZ_ST_RUN   = 4'h0,
        SPACZ_ST_POL1  = 4'h1,
        SPACZ_ST_POL2  = 4'h3,
        SPACZ_ST_POL3  = 4'h2,
        SPACZ_ST_POL4  = 4'h6,
        SPACZ_ST_CBLW  = 4'h7,
        SPACZ_ST_COL1  = 4'h5,
        SPACZ_ST_COL2  = 4'h4,
        SPACZ_ST_COL3  = 4'hC,
        SPACZ_ST_COL4  = 4'hD
    } spacz_state_t;
endpackage : spacz_pkg

//--- hdl/spacz_debounce.sv
// Module: three-stage synchroniser and debounce filter for one pin
`timescale 1ns/100ps
`default_nettype none
module spacz_debounce #(
    parameter int unsigned SETTLE = spacz_pkg::DEB_CYCLES
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic clk_en,
    // Pin and clean level
    input  wire logic pin_in,
    output logic      level_out
);
    logic [2:0]                      sync_reg;
    logic [spacz_pkg::DEB_W+1:0]     cnt_reg;
    logic                            level_reg;
    wire                             agree = (sync_reg[1] == sync_reg[2]);
    wire                             diff  = (sync_reg[2] != level_reg);
    wire                             done  = (cnt_reg >= (spacz_pkg::DEB_W+2)'(SETTLE - 1));

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync_reg  <= 3'h0;
            cnt_reg   <= '0;
            level_reg <= 1'b0;
        end else if (clk_en) begin
            sync_reg <= {sync_reg[1:0], pin_in};
            // A level counts only while stages two and three agree
            if (!(agree && diff)) begin
                cnt_reg <= '0;
            end else if (done) begin
                cnt_reg   <= '0;
                level_reg <= sync_reg[2];
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end
    assign level_out = level_reg;
endmodule // spacz_debounce
`default_nettype wire

//--- hdl/spacz_top.sv
// Module: setpoint relays, tricolour bar colour and programming menu
`timescale 1ns/100ps
`default_nettype none
module spacz_top #(
    parameter int unsigned SETTLE = spacz_pkg::DEB_CYCLES
) (
    // Clock, reset and enable
    input  wire logic                     clk_sys,
    input  wire logic                     reset,
    input  wire logic                     clk_en,
    // Measurement and setpoints
    input  wire logic signed [15:0]       reading,
    input  wire logic signed [15:0]       setpoint_one,
    input  wire logic signed [15:0]       setpoint_two,
    input  wire logic signed [15:0]       setpoint_three,
    input  wire logic signed [15:0]       setpoint_four,
    // Configuration
    input  wire logic                     tricolor_fitted,
    input  wire logic [7:0]               brightness_set,
    // Front keys and rear pins, raw, key active high, rear pins active low
    input  wire logic                     key_prog,
    input  wire logic                     key_up,
    input  wire logic                     key_down,
    input  wire logic                     menu_enter,
    input  wire logic                     lock_n,
    input  wire logic                     dim_n,
    // Outputs
    output logic [3:0]                    relay_out,
    output logic [1:0]                    bar_color,
    output logic [7:0]                    brightness_out,
    output logic [3:0]                    relay_polarity_fields,
    output logic [1:0]                    zone_color_below,
    output logic [1:0]                    zone_color_one,
    output logic [1:0]                    zone_color_two,
    output logic [1:0]                    zone_color_three,
    output logic [1:0]                    zone_color_four,
    output logic [3:0]                    menu_state,
    output logic [3:0]                    field_flash,
    output logic                          edit_refused
);
    logic [5:0] raw;
    logic [5:0] clean;
    logic [5:0] clean_d_reg;
    logic [5:0] rise;
    spacz_pkg::spacz_state_t state_reg;
    spacz_pkg::spacz_state_t state_next;
    logic [3:0] pol_reg;
    logic [1:0] col_reg [0:4];
    logic [3:0] relay_reg;
    logic [1:0] bar_reg;
    logic [7:0] bright_reg;
    logic       refused_reg;

    assign raw = {~dim_n, ~lock_n, menu_enter, key_down, key_up, key_prog};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_deb
            spacz_debounce #(.SETTLE(SETTLE)) u_deb (
                .clk_sys   (clk_sys),
                .reset     (reset),
                .clk_en    (clk_en),
                .pin_in    (raw[gi]),
                .level_out (clean[gi])
            );
        end
    endgenerate

    assign rise = clean & ~clean_d_reg;
    wire p_prog  = rise[0];
    wire p_adj   = rise[1] | rise[2];
    wire p_enter = rise[3];
    wire p_up    = rise[1];
    wire locked  = clean[4];
    wire dimmed  = clean[5];

    // Next colour, only the three legal values
    function automatic logic [1:0] step_color(input logic [1:0] c, input logic up);
        logic [1:0] r;
        r = c;
        if (up) begin
            r = (c == 2'h2) ? 2'h0 : c + 2'h1;
        end else begin
            r = (c == 2'h0) ? 2'h2 : c - 2'h1;
        end
        return (r > 2'h2) ? 2'h0 : r;
    endfunction

    wire signed [15:0] sp [0:3];
    assign sp[0] = setpoint_one;
    assign sp[1] = setpoint_two;
    assign sp[2] = setpoint_three;
    assign sp[3] = setpoint_four;

    logic [3:0] above;
    logic [3:0] below;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            above[i] = reading > sp[i];
            below[i] = reading < sp[i];
        end
    end
    wire [3:0] relay_next = (pol_reg & above) | (~pol_reg & below);

    // Winner: greatest exceeded setpoint; later index wins ties via >=
    logic [2:0] win;
    logic signed [15:0] best;
    always_comb begin
        win  = 3'h0;
        best = 16'sh0;
        for (int i = 0; i < 4; i++) begin
            if (above[i] && (win == 3'h0 || sp[i] >= best)) begin
                win  = 3'(i + 1);
                best = sp[i];
            end
        end
    end
    wire [1:0] bar_next = col_reg[win];

    wire [2:0] pol_idx = 3'(state_reg == spacz_pkg::SPACZ_ST_POL1 ? 0 :
                            state_reg == spacz_pkg::SPACZ_ST_POL2 ? 1 :
                            state_reg == spacz_pkg::SPACZ_ST_POL3 ? 2 :
                            state_reg == spacz_pkg::SPACZ_ST_POL4 ? 3 : 7);
    wire [2:0] col_idx = 3'(state_reg == spacz_pkg::SPACZ_ST_CBLW ? 0 :
                            state_reg == spacz_pkg::SPACZ_ST_COL1 ? 1 :
                            state_reg == spacz_pkg::SPACZ_ST_COL2 ? 2 :
                            state_reg == spacz_pkg::SPACZ_ST_COL3 ? 3 :
                            state_reg == spacz_pkg::SPACZ_ST_COL4 ? 4 : 7);
    wire edit_try = p_adj && (pol_idx != 3'h7 || col_idx != 3'h7);
    wire edit_ok  = edit_try && !locked;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            spacz_pkg::SPACZ_ST_RUN:  if (p_enter) state_next = spacz_pkg::SPACZ_ST_POL1;
            spacz_pkg::SPACZ_ST_POL1: if (p_prog) state_next = spacz_pkg::SPACZ_ST_POL2;
            spacz_pkg::SPACZ_ST_POL2: if (p_prog) state_next = spacz_pkg::SPACZ_ST_POL3;
            spacz_pkg::SPACZ_ST_POL3: if (p_prog) state_next = spacz_pkg::SPACZ_ST_POL4;
            spacz_pkg::SPACZ_ST_POL4: if (p_prog) begin
                state_next = tricolor_fitted ? spacz_pkg::SPACZ_ST_CBLW : spacz_pkg::SPACZ_ST_RUN;
            end
            spacz_pkg::SPACZ_ST_CBLW: if (p_prog) state_next = spacz_pkg::SPACZ_ST_COL1;
            spacz_pkg::SPACZ_ST_COL1: if (p_prog) state_next = spacz_pkg::SPACZ_ST_COL2;
            spacz_pkg::SPACZ_ST_COL2: if (p_prog) state_next = spacz_pkg::SPACZ_ST_COL3;
            spacz_pkg::SPACZ_ST_COL3: if (p_prog) state_next = spacz_pkg::SPACZ_ST_COL4;
            spacz_pkg::SPACZ_ST_COL4: if (p_prog) state_next = spacz_pkg::SPACZ_ST_RUN;
            default:                  state_next = spacz_pkg::SPACZ_ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            clean_d_reg <= 6'h00;
            state_reg   <= spacz_pkg::SPACZ_ST_RUN;
            pol_reg     <= spacz_pkg::POL_RESET;
            for (int i = 0; i < 5; i++) col_reg[i] <= 2'h0;
            relay_reg   <= 4'h0;
            bar_reg     <= 2'h0;
            bright_reg  <= spacz_pkg::BRIGHT_RESET;
            refused_reg <= 1'b0;
        end else if (clk_en) begin
            clean_d_reg <= clean;
            state_reg   <= state_next;
            relay_reg   <= relay_next;
            bar_reg     <= bar_next;
            // Halving by shift keeps the programmed scale monotonic
            bright_reg  <= dimmed ? {1'b0, brightness_set[7:1]} : brightness_set;
            refused_reg <= edit_try && locked;
            if (edit_ok && pol_idx != 3'h7) begin
                pol_reg[pol_idx[1:0]] <= ~pol_reg[pol_idx[1:0]];
            end
            if (edit_ok && col_idx != 3'h7) begin
                col_reg[col_idx] <= step_color(col_reg[col_idx], p_up);
            end
        end
    end

    assign relay_out             = relay_reg;
    assign bar_color             = bar_reg;
    assign brightness_out        = bright_reg;
    assign relay_polarity_fields = pol_reg;
    assign zone_color_below      = col_reg[0];
    assign zone_color_one        = col_reg[1];
    assign zone_color_two        = col_reg[2];
    assign zone_color_three      = col_reg[3];
    assign zone_color_four       = col_reg[4];
    assign menu_state            = state_reg;
    assign field_flash           = (pol_idx == 3'h7) ? 4'h0 : 4'(4'h1 << pol_idx[1:0]);
    assign edit_refused          = refused_reg;

    chk_relay_high_pol: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && pol_reg[0] && above[0] |=> relay_out[0] || !$past(clk_en))
        else $error("relay one not energised above setpoint");
    chk_relay_low_pol: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && !pol_reg[1] && below[1] |=> relay_out[1] || !$past(clk_en))
        else $error("relay two not energised below setpoint");
    chk_color_legal: assert property (@(posedge clk_sys) disable iff (reset)
        bar_color != 2'h3)
        else $error("illegal bar colour");
    chk_below_zone: assert property (@(posedge clk_sys) disable iff (reset)
        // The bar takes the colour as it stood at the deciding edge, even if edited there
        clk_en && above == 4'h0 |=> bar_color == $past(zone_color_below))
        else $error("below-zone colour not shown");
    chk_tie_top: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && above[3] && sp[3] >= sp[2] && sp[3] >= sp[1] && sp[3] >= sp[0]
        |=> bar_color == $past(zone_color_four))
        else $error("setpoint four colour lost tie");
    chk_lock_hold: assert property (@(posedge clk_sys) disable iff (reset)
        locked |=> $stable(relay_polarity_fields) && $stable(zone_color_below))
        else $error("edit accepted while locked");
    chk_mono_exit: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && state_reg == spacz_pkg::SPACZ_ST_POL4 && p_prog && !tricolor_fitted
        |=> menu_state == spacz_pkg::SPACZ_ST_RUN)
        else $error("mono variant did not exit");
    chk_dim_half: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && dimmed |=> brightness_out == ($past(brightness_set) >> 1))
        else $error("dim did not halve brightness");
    cov_tricolor_enter: cover property (@(posedge clk_sys)
        menu_state == spacz_pkg::SPACZ_ST_CBLW);
    cov_lock_refuse: cover property (@(posedge clk_sys) edit_refused);
    cov_relay_all: cover property (@(posedge clk_sys) relay_out == 4'hF);
endmodule // spacz_top
`default_nettype wire

//--- sim/spacz_panel_model.sv
// Front panel model: presses one key, holds it, then releases it
`timescale 1ns/100ps
`default_nettype none
module spacz_panel_model #(
    parameter int HOLD = 16
) (
    // Clock
    input  wire logic       clk_sys,
    // Request from the bench and key pins to the block
    input  wire logic [3:0] press,
    output logic [3:0]      keys,
    output logic            busy
);
    int cnt = 0;
    initial keys = 4'h0;
    // Release lasts as long as the press, so the debouncer always sees a clean edge
    // Plain always: the initial block above also writes keys
    always @(posedge clk_sys) begin
        if (cnt == 0 && press != 4'h0) begin
            keys <= press;
            cnt  <= 2 * HOLD;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == HOLD) begin
                keys <= 4'h0;
            end
        end
    end
    assign busy = (cnt != 0);
endmodule // spacz_panel_model
`default_nettype wire

//--- sim/spacz_top_tb.sv
// Testbench for the setpoint relay and colour-zone block
`timescale 1ns/100ps
`default_nettype none
module spacz_top_tb;
    logic clk_sys, reset, clk_en, tricolor_fitted, lock_n, dim_n, busy, edit_refused;
    logic signed [15:0] reading, sp1, sp2, sp3, sp4;
    logic [7:0] brightness_set, brightness_out, bval;
    logic [3:0] press, keys, relay_out, relay_polarity_fields, menu_state, field_flash, pol;
    logic [1:0] bar_color, zcb, zc1, zc2, zc3, zc4;
    logic [1:0] zc_exp [5];
    logic [5:0] note_q [$];
    int n_mismatch, tests_run, n_refused, cycles;
    event res_ev;

    spacz_top #(.SETTLE(4)) i_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .reading(reading),
        .setpoint_one(sp1), .setpoint_two(sp2), .setpoint_three(sp3), .setpoint_four(sp4),
        .tricolor_fitted(tricolor_fitted), .brightness_set(brightness_set), .key_prog(keys[0]),
        .key_up(keys[1]), .key_down(keys[2]), .menu_enter(keys[3]), .lock_n(lock_n), .dim_n(dim_n),
        .relay_out(relay_out), .bar_color(bar_color), .brightness_out(brightness_out),
        .relay_polarity_fields(relay_polarity_fields), .zone_color_below(zcb), .zone_color_one(zc1),
        .zone_color_two(zc2), .zone_color_three(zc3), .zone_color_four(zc4), .menu_state(menu_state),
        .field_flash(field_flash), .edit_refused(edit_refused));
    spacz_panel_model #(.HOLD(16)) i_panel (.clk_sys(clk_sys), .press(press), .keys(keys), .busy(busy));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        $display("Counts: %0d compares, %0d mismatches", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic push_key(input logic [3:0] k);
        @(posedge clk_sys) press <= k;
        @(posedge clk_sys) press <= 4'h0;
        @(posedge clk_sys);
        for (int i = 0; i < 200 && busy; i++) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
    endtask

    // Setpoints drawn from four values so that ties come up often
    task automatic zone_test(input int n);
        int r, w;
        int s [4];
        logic [3:0] rel;
        for (int t = 0; t < n; t++) begin
            r = int'($urandom_range(200)) - 80;
            foreach (s[i]) s[i] = 50 * int'($urandom_range(3)) - 50;
            w = -1;
            for (int i = 0; i < 4; i++) begin
                rel[i] = pol[i] ? (r > s[i]) : (r < s[i]);
                if (r > s[i] && (w < 0 || s[i] >= s[w])) w = i;
            end
            @(posedge clk_sys);
            reading <= 16'(r);
            sp1 <= 16'(s[0]);
            sp2 <= 16'(s[1]);
            sp3 <= 16'(s[2]);
            sp4 <= 16'(s[3]);
            repeat (2) @(posedge clk_sys);
            note_q.push_back({rel, (w < 0) ? zc_exp[0] : zc_exp[w + 1]});
            -> res_ev;
        end
        $display("zone test done");
    endtask

    always @(res_ev) begin
        if (note_q.size() != 0) begin
            cmp(8'({relay_out, bar_color}), 8'(note_q.pop_front()), "relay/colour");
        end
    end

    always @(posedge clk_sys) begin
        if (edit_refused === 1'b1) n_refused++;
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            $display("unexpected at %0t: run timed out", $time);
            close_out();
        end
    end

    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        tricolor_fitted = 1'b1;
        lock_n = 1'b1;
        dim_n = 1'b1;
        press = 4'h0;
        reading = '0;
        {sp1, sp2, sp3, sp4} = '0;
        brightness_set = 8'h80;
        n_mismatch = 0;
        tests_run = 0;
        n_refused = 0;
        cycles = 0;
        void'($urandom(32'h8078));
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        cmp(8'(relay_polarity_fields), 8'h0F, "pol reset");
        cmp(8'(menu_state), 8'h00, "state reset");
        $display("reset test done");
        // Program polarity then colours on a tricolour unit
        push_key(4'h8);
        cmp(8'(field_flash), 8'h01, "flash one");
        push_key(4'h2);
        cmp(8'(relay_polarity_fields), 8'h0E, "pol one");
        push_key(4'h1);
        push_key(4'h4);
        cmp(8'({menu_state, field_flash}), 8'h32, "pol two");
        cmp(8'(relay_polarity_fields), 8'h0C, "pol two");
        push_key(4'h1);
        push_key(4'h1);
        push_key(4'h1);
        cmp(8'(menu_state), 8'h07, "below prompt");
        push_key(4'h2);
        push_key(4'h1);
        push_key(4'h2);
        push_key(4'h2);
        cmp(8'({zcb, zc1}), 8'h06, "colour red");
        push_key(4'h2);
        cmp(8'(zc1), 8'h00, "colour wrap");
        push_key(4'h2);
        push_key(4'h1);
        push_key(4'h1);
        push_key(4'h2);
        push_key(4'h2);
        push_key(4'h1);
        push_key(4'h2);
        push_key(4'h1);
        cmp(8'(menu_state), 8'h00, "colour exit");
        cmp(8'({zc2, zc3, zc4}), 8'h09, "colour values");
        $display("menu test done");
        zc_exp = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h1};
        pol = 4'hC;
        zone_test(60);
        // A low clock enable must hold the relays while the reading moves
        @(posedge clk_sys);
        reading <= 16'hFFF6;
        {sp1, sp2, sp3, sp4} <= '0;
        repeat (2) @(posedge clk_sys);
        cmp(8'(relay_out), 8'h03, "pre-freeze");
        clk_en <= 1'b0;
        reading <= 16'h000A;
        repeat (4) @(posedge clk_sys);
        cmp(8'(relay_out), 8'h03, "frozen");
        clk_en <= 1'b1;
        repeat (2) @(posedge clk_sys);
        cmp(8'(relay_out), 8'h0C, "thawed");
        $display("freeze test done");
        // Locked edit on a single-colour unit
        @(posedge clk_sys);
        lock_n <= 1'b0;
        tricolor_fitted <= 1'b0;
        push_key(4'h8);
        push_key(4'h2);
        cmp(8'(n_refused), 8'h01, "refused pulse");
        cmp(8'(relay_polarity_fields), 8'h0C, "locked pol");
        repeat (4) push_key(4'h1);
        cmp(8'(menu_state), 8'h00, "mono exit");
        lock_n <= 1'b1;
        $display("lock test done");
        bval = 8'($urandom_range(255));
        brightness_set <= bval;
        dim_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        cmp(brightness_out, bval >> 1, "dimmed");
        dim_n <= 1'b1;
        repeat (20) @(posedge clk_sys);
        cmp(brightness_out, bval, "full");
        $display("dim test done");
        close_out();
    end
endmodule // spacz_top_tb
`default_nettype wire
